// ---- rtl/macfs_pkg.sv ----
// package: register map, field layout and types of the format and status block
package macfs_pkg;
  localparam int unsigned ADR_W   = 8;
  localparam int unsigned DAT_W   = 32;
  localparam int unsigned ACC_W   = 40;
  localparam int unsigned HALF_W  = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned SHAMT_W = 5;
  localparam int unsigned EXP_W   = 5;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_OPA  = 8'h08;
  localparam logic [7:0] OFF_OPB  = 8'h0c;
  localparam logic [7:0] OFF_CMD  = 8'h10;
  localparam logic [7:0] OFF_RES  = 8'h14;
  localparam logic [7:0] OFF_A0W  = 8'h18;
  localparam logic [7:0] OFF_A0X  = 8'h1c;
  localparam logic [7:0] OFF_A1W  = 8'h20;
  localparam logic [7:0] OFF_A1X  = 8'h24;
  localparam logic [7:0] OFF_RND  = 8'h28;

  // control register
  localparam int unsigned CTRL_RBS_BIT  = 0;
  localparam int unsigned CTRL_FRAC_BIT = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h0;

  // command register
  localparam int unsigned CMD_OP_W    = 4;
  localparam int unsigned CMD_SEL_BIT = 4;
  localparam int unsigned CMD_SUB_BIT = 5;
  localparam int unsigned CMD_RND_BIT = 6;
  localparam int unsigned CMD_H16_BIT = 7;

  localparam logic [15:0] RND_MID  = 16'h8000;
  localparam logic [39:0] RND_ADD  = 40'h0000008000;
  localparam int unsigned RND_LSB  = 16;
  localparam int unsigned STAT_W   = 10;

  typedef enum logic [CMD_OP_W-1:0] {
    OP_LDU16, OP_LDS16, OP_LDU8, OP_LDS8, OP_LDFRAC, OP_PACKED,
    OP_ADD, OP_MAC, OP_XFER, OP_LSL, OP_LSR, OP_ASR, OP_EXP
  } macfs_op_e;

  // arith_status_word, bit 0 is the last field
  typedef struct packed {
    logic acc_transfer_overflow_sticky;
    logic acc_transfer_overflow;
    logic alu1_overflow_sticky;
    logic alu0_overflow_sticky;
    logic alu1_overflow;
    logic alu0_overflow;
    logic alu1_carry;
    logic alu0_carry;
    logic alu_negative_flag;
    logic result_zero;
  } macfs_stat_s;

  localparam macfs_stat_s STAT_RST = '0;
endpackage : macfs_pkg

// ---- rtl/macfs_core.sv ----
// format, accumulate and status logic behind a classic wishbone slave
// Function
// RULE1 - unsigned half word or byte loads fill upper register bits with zeros
// RULE2 - signed half word or byte loads replicate the sign into upper bits
// RULE3 - a 1.15 fraction sits in the low half, sign copied upward
// RULE4 - packed fractions or bytes keep the memory layout inside the register
// RULE5 - multi-byte data uses little endian byte order
// RULE6 - alu works on 16 or 32 bit strings, flags read results as signed
// RULE7 - each alu has a sticky overflow held until the status word is written
// RULE8 - transfer overflow follows both accumulator moves, its sticky copy holds
// RULE9 - overflow is two's complement; opposite-sign addition never overflows
// RULE10 - carry is the unsigned carry out of the top bit
// RULE11 - the 32-bit product is signed and sign-extended to 40 bits
// RULE12 - fractional mode shifts the 2.30 product left to 1.31
// RULE13 - fractional product bit 31 lands on accumulator bit 32, bit 0 zero
// RULE14 - integer mode adds the product unshifted
// RULE15 - product is added to or subtracted from the accumulator in 40 bits
// RULE16 - flags update on accumulator writes and on transfers to registers
// RULE17 - logical shifts are unsigned, arithmetic shift and exponent are signed
// RULE18 - bias select 0 means unbiased rounding, 1 means biased
// RULE19 - unbiased rounding adds at bit 15 and forces bit 16 low at midpoint
// RULE20 - biased rounding always rounds the midpoint upward
// RULE21 - rounding only writes the 16-bit output, accumulators stay unrounded
// RULE22 - all results of one operation appear together on one clock edge
`timescale 1ns/100ps
module macfs_core
  import macfs_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_arst_n,
  input  wire logic              i_wb_cyc,
  input  wire logic              i_wb_stb,
  input  wire logic              i_wb_we,
  input  wire logic [ADR_W-1:0]  i_wb_adr,
  input  wire logic [SEL_W-1:0]  i_wb_sel,
  input  wire logic [DAT_W-1:0]  i_wb_dat,
  output logic      [DAT_W-1:0]  o_wb_dat,
  output logic                   o_wb_ack,
  output macfs_stat_s            o_status
);

  function automatic logic [DAT_W-1:0] merge(input logic [DAT_W-1:0] old_v,
                                             input logic [DAT_W-1:0] new_v,
                                             input logic [SEL_W-1:0] sel);
    logic [DAT_W-1:0] r;
    r = old_v;
    for (int i = 0; i < SEL_W; i++) begin
      if (sel[i]) begin
        r[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
      end
    end
    return r;
  endfunction : merge

  // accumulator fits a signed 32-bit register when bits 39..31 agree
  function automatic logic fits32(input logic [ACC_W-1:0] a);
    return (&a[ACC_W-1:DAT_W-1]) | ~(|a[ACC_W-1:DAT_W-1]);
  endfunction : fits32

  function automatic logic [HALF_W-1:0] round16(input logic [ACC_W-1:0] a,
                                                input logic biased);
    logic [ACC_W-1:0] s;
    s = a + RND_ADD;
    if (!biased && a[HALF_W-1:0] == RND_MID) begin
      s[RND_LSB] = 1'b0; // RULE19
    end
    return s[RND_LSB +: HALF_W]; // RULE20
  endfunction : round16

  logic [1:0]       ctrl_q;
  logic [DAT_W-1:0] opa_q, opb_q, res_q, cmd_q, dat_q;
  logic [ACC_W-1:0] acc0_q, acc1_q;
  logic [HALF_W-1:0] rnd_q;
  logic             ack_q;
  macfs_stat_s      stat_q;

  logic             req, wr_now, op_fire, stat_wr;
  logic [DAT_W-1:0] cmd_w;
  macfs_op_e        op;
  logic             sel1, sub, rnd_on, h16, frac, rbs;

  assign req     = i_wb_cyc & i_wb_stb;
  // a write lands on the edge where the master sees ack, never earlier
  assign wr_now  = req & i_wb_we & ack_q;
  assign stat_wr = wr_now & (i_wb_adr == OFF_STAT);
  assign op_fire = wr_now & (i_wb_adr == OFF_CMD) & i_wb_sel[0];
  assign cmd_w   = merge(cmd_q, i_wb_dat, i_wb_sel);
  assign op      = macfs_op_e'(cmd_w[CMD_OP_W-1:0]);
  assign sel1    = cmd_w[CMD_SEL_BIT];
  assign sub     = cmd_w[CMD_SUB_BIT];
  assign rnd_on  = cmd_w[CMD_RND_BIT];
  assign h16     = cmd_w[CMD_H16_BIT];
  assign frac    = ctrl_q[CTRL_FRAC_BIT];
  assign rbs     = ctrl_q[CTRL_RBS_BIT];

  // ---------------- datapath ----------------
  logic [DAT_W-1:0]  res_d;
  logic [ACC_W-1:0]  acc0_d, acc1_d;
  logic [HALF_W-1:0] rnd_d;
  macfs_stat_s       stat_d;
  logic [HALF_W-1:0] ld_half;
  logic [BYTE_W-1:0] ld_byte;
  logic [DAT_W-1:0]  bb, stat_m;
  logic [DAT_W:0]    sum33;
  logic [HALF_W:0]   sum17;
  logic              a_ov, a_c;
  logic signed [DAT_W-1:0] prod;
  logic [ACC_W-1:0]  addend, acc_cur, acc_new;
  logic              m_ov;
  logic [EXP_W-1:0]  expo;

  always_comb begin
    res_d   = res_q;
    acc0_d  = acc0_q;
    acc1_d  = acc1_q;
    rnd_d   = rnd_q;
    stat_d  = stat_q;
    a_ov    = 1'b0;
    a_c     = 1'b0;
    m_ov    = 1'b0;
    expo    = '0;
    // little endian: lane 0 is bits 7..0, lane 1 the next byte up
    ld_half = opb_q[1] ? opa_q[DAT_W-1:HALF_W] : opa_q[HALF_W-1:0]; // RULE5
    ld_byte = opa_q[{opb_q[1:0], 3'h0} +: BYTE_W]; // RULE5
    bb      = sub ? ~opb_q : opb_q;
    sum33   = {1'b0, opa_q} + {1'b0, bb} + {{DAT_W{1'b0}}, sub};
    sum17   = {1'b0, opa_q[HALF_W-1:0]} + {1'b0, bb[HALF_W-1:0]}
              + {{HALF_W{1'b0}}, sub};
    prod    = $signed(opa_q[HALF_W-1:0]) * $signed(opb_q[HALF_W-1:0]);
    if (frac) begin
      addend = {{(ACC_W-DAT_W-1){prod[DAT_W-1]}}, prod, 1'b0}; // RULE12 RULE13
    end else begin
      addend = {{(ACC_W-DAT_W){prod[DAT_W-1]}}, prod}; // RULE11 RULE14
    end
    acc_cur = sel1 ? acc1_q : acc0_q;
    acc_new = sub ? acc_cur - addend : acc_cur + addend; // RULE15
    for (int i = DAT_W-2; i >= 0; i--) begin
      if (opa_q[i] == opa_q[DAT_W-1] && 32'(expo) == DAT_W-2-i) begin
        expo = expo + 1'b1; // RULE17
      end
    end
    if (op_fire) begin
      case (op)
        OP_LDU16:  res_d = {{HALF_W{1'b0}}, ld_half}; // RULE1
        OP_LDS16:  res_d = {{HALF_W{ld_half[HALF_W-1]}}, ld_half}; // RULE2
        OP_LDU8:   res_d = {{(DAT_W-BYTE_W){1'b0}}, ld_byte}; // RULE1
        OP_LDS8:   res_d = {{(DAT_W-BYTE_W){ld_byte[BYTE_W-1]}}, ld_byte}; // RULE2
        OP_LDFRAC: res_d = {{HALF_W{opa_q[HALF_W-1]}}, opa_q[HALF_W-1:0]}; // RULE3
        OP_PACKED: res_d = opa_q; // RULE4
        OP_ADD: begin
          if (h16) begin
            res_d = {{HALF_W{1'b0}}, sum17[HALF_W-1:0]}; // RULE6
            a_c   = sum17[HALF_W]; // RULE10
            a_ov  = (opa_q[HALF_W-1] == bb[HALF_W-1])
                    & (sum17[HALF_W-1] != opa_q[HALF_W-1]); // RULE9
          end else begin
            res_d = sum33[DAT_W-1:0]; // RULE6
            a_c   = sum33[DAT_W]; // RULE10
            a_ov  = (opa_q[DAT_W-1] == bb[DAT_W-1])
                    & (sum33[DAT_W-1] != opa_q[DAT_W-1]); // RULE9
          end
        end
        OP_MAC: begin
          m_ov = (acc_cur[ACC_W-1] == (addend[ACC_W-1] ^ sub))
                 & (acc_new[ACC_W-1] != acc_cur[ACC_W-1]); // RULE9
          if (sel1) begin
            acc1_d = acc_new;
          end else begin
            acc0_d = acc_new;
          end
        end
        OP_XFER: begin
          res_d = sel1 ? acc1_q[DAT_W-1:0] : acc0_q[DAT_W-1:0];
          if (rnd_on) begin
            rnd_d = round16(acc_cur, rbs); // RULE18 RULE21
          end
        end
        OP_LSL:  res_d = opa_q << opb_q[SHAMT_W-1:0];
        OP_LSR:  res_d = opa_q >> opb_q[SHAMT_W-1:0]; // RULE17
        OP_ASR:  res_d = DAT_W'($signed(opa_q) >>> opb_q[SHAMT_W-1:0]); // RULE17
        OP_EXP:  res_d = {{(DAT_W-EXP_W){1'b0}}, expo};
        default: res_d = res_q;
      endcase
    end
    // status word: a direct write loads it, hardware events then win
    stat_m  = merge({{(DAT_W-STAT_W){1'b0}}, stat_q}, i_wb_dat, i_wb_sel);
    if (stat_wr) begin
      stat_d = macfs_stat_s'(stat_m[STAT_W-1:0]); // RULE7
    end
    if (op_fire && op != OP_MAC) begin
      stat_d.result_zero       = (res_d == '0);
      stat_d.alu_negative_flag = res_d[h16 && op == OP_ADD ? HALF_W-1 : DAT_W-1];
      if (op == OP_LDU16 || op == OP_LDU8) begin
        stat_d.alu_negative_flag = 1'b0;
      end
    end
    if (op_fire && op == OP_ADD) begin
      if (sel1) begin
        stat_d.alu1_overflow = a_ov;
        stat_d.alu1_carry    = a_c;
        stat_d.alu1_overflow_sticky = stat_d.alu1_overflow_sticky | a_ov; // RULE7
      end else begin
        stat_d.alu0_overflow = a_ov;
        stat_d.alu0_carry    = a_c;
        stat_d.alu0_overflow_sticky = stat_d.alu0_overflow_sticky | a_ov; // RULE7
      end
    end
    if (op_fire && op == OP_MAC) begin
      stat_d.result_zero       = (acc_new == '0); // RULE16
      stat_d.alu_negative_flag = acc_new[ACC_W-1];
      if (sel1) begin
        stat_d.alu1_overflow = m_ov;
        stat_d.alu1_overflow_sticky = stat_d.alu1_overflow_sticky | m_ov;
      end else begin
        stat_d.alu0_overflow = m_ov;
        stat_d.alu0_overflow_sticky = stat_d.alu0_overflow_sticky | m_ov;
      end
    end
    if (op_fire && op == OP_XFER) begin
      stat_d.acc_transfer_overflow = ~fits32(acc0_q) | ~fits32(acc1_q); // RULE8 RULE16
      stat_d.acc_transfer_overflow_sticky = stat_d.acc_transfer_overflow_sticky
                                            | stat_d.acc_transfer_overflow; // RULE8
    end
  end

  // ---------------- bus slave ----------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dat_q <= '0;
    end else if (req & ~ack_q) begin
      case (i_wb_adr)
        OFF_CTRL: dat_q <= {{(DAT_W-2){1'b0}}, ctrl_q};
        OFF_STAT: dat_q <= {{(DAT_W-STAT_W){1'b0}}, stat_q};
        OFF_OPA:  dat_q <= opa_q;
        OFF_OPB:  dat_q <= opb_q;
        OFF_CMD:  dat_q <= cmd_q;
        OFF_RES:  dat_q <= res_q;
        OFF_A0W:  dat_q <= acc0_q[DAT_W-1:0];
        OFF_A0X:  dat_q <= {{(2*DAT_W-ACC_W){acc0_q[ACC_W-1]}}, acc0_q[ACC_W-1:DAT_W]};
        OFF_A1W:  dat_q <= acc1_q[DAT_W-1:0];
        OFF_A1X:  dat_q <= {{(2*DAT_W-ACC_W){acc1_q[ACC_W-1]}}, acc1_q[ACC_W-1:DAT_W]};
        OFF_RND:  dat_q <= {{HALF_W{1'b0}}, rnd_q};
        default:  dat_q <= '0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q <= CTRL_RST;
      opa_q  <= '0;
      opb_q  <= '0;
      cmd_q  <= '0;
    end else if (wr_now) begin
      if (i_wb_adr == OFF_CTRL && i_wb_sel[0]) begin
        ctrl_q <= i_wb_dat[1:0];
      end
      if (i_wb_adr == OFF_OPA) begin
        opa_q <= merge(opa_q, i_wb_dat, i_wb_sel);
      end
      if (i_wb_adr == OFF_OPB) begin
        opb_q <= merge(opb_q, i_wb_dat, i_wb_sel);
      end
      if (i_wb_adr == OFF_CMD) begin
        cmd_q <= cmd_w;
      end
    end
  end

  // every product of one command commits on the same edge
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      res_q  <= '0;
      acc0_q <= '0;
      acc1_q <= '0;
      rnd_q  <= '0;
      stat_q <= STAT_RST;
    end else begin
      res_q  <= res_d; // RULE22
      acc0_q <= acc0_d;
      acc1_q <= acc1_d;
      rnd_q  <= rnd_d;
      stat_q <= stat_d; // RULE22
    end
  end

  assign o_wb_dat = dat_q;
  assign o_wb_ack = ack_q;
  assign o_status = stat_q;

  // ---------------- checks ----------------
  logic [BYTE_W-1:0] opa_b0;
  logic              add_opp;
  assign opa_b0  = opa_q[BYTE_W-1:0];
  assign add_opp = (opa_q[DAT_W-1] ^ opb_q[DAT_W-1]) & ~h16 & ~sub;

  a_zero_ext_hw: assert property ( // RULE1
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_LDU16 |=> res_q[DAT_W-1:HALF_W] == '0 && !stat_q.alu_negative_flag)
    else $error("unsigned half word not zero extended");
  a_sign_ext_byte: assert property ( // RULE2
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_LDS8 |=> res_q[DAT_W-1:BYTE_W] == {(DAT_W-BYTE_W){res_q[BYTE_W-1]}})
    else $error("signed byte not sign extended");
  a_frac_layout: assert property ( // RULE3
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_LDFRAC |=> res_q[DAT_W-1:HALF_W] == {HALF_W{res_q[HALF_W-1]}})
    else $error("fraction sign not copied upward");
  a_packed_keep: assert property ( // RULE4
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_PACKED |=> res_q == $past(opa_q))
    else $error("packed data reordered");
  a_lane_zero: assert property ( // RULE5
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_LDU8 && opb_q[1:0] == 2'h0 |=> res_q[BYTE_W-1:0] == $past(opa_b0))
    else $error("byte lane 0 is not the low byte");
  a_sticky_hold: assert property ( // RULE7
    @(posedge i_mclk) disable iff (!i_arst_n)
    stat_q.alu0_overflow_sticky && !stat_wr |=> stat_q.alu0_overflow_sticky)
    else $error("alu0 sticky overflow dropped without a write");
  a_xfer_sticky: assert property ( // RULE8
    @(posedge i_mclk) disable iff (!i_arst_n)
    stat_q.acc_transfer_overflow && !$past(stat_wr) |-> stat_q.acc_transfer_overflow_sticky)
    else $error("transfer overflow without its sticky copy");
  a_no_opp_ovf: assert property ( // RULE9
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_ADD && add_opp && !sel1 |=> !stat_q.alu0_overflow)
    else $error("opposite sign addition flagged overflow");
  a_frac_lsb: assert property ( // RULE13
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_MAC && frac
    |=> acc0_q[0] == $past(acc0_q[0]) && acc1_q[0] == $past(acc1_q[0]))
    else $error("fractional product reached accumulator bit 0");
  a_unbiased_mid: assert property ( // RULE19
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_XFER && rnd_on && !rbs && !sel1 && acc0_q[HALF_W-1:0] == RND_MID
    |=> rnd_q[0] == 1'b0)
    else $error("midpoint not rounded to even");
  a_acc_unrounded: assert property ( // RULE21
    @(posedge i_mclk) disable iff (!i_arst_n)
    op_fire && op == OP_XFER |=> $stable(acc0_q) && $stable(acc1_q))
    else $error("accumulator changed by a transfer");
  a_ack_single: assert property ( // RULE22
    @(posedge i_mclk) disable iff (!i_arst_n)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held for two cycles");

endmodule : macfs_core

// ---- rtl/macfs_core_notes_unused.sv ----
// holds no logic; the whole block lives in macfs_core

// ---- tb/macfs_host_model.sv ----
// wishbone host model standing in for the sequencer and register file side
`timescale 1ns/100ps
module macfs_host_model
  import macfs_pkg::*;
(
  input  wire logic             i_mclk,
  input  wire logic             i_wb_ack,
  input  wire logic [DAT_W-1:0] i_wb_dat,
  output logic                  o_wb_cyc,
  output logic                  o_wb_stb,
  output logic                  o_wb_we,
  output logic      [ADR_W-1:0] o_wb_adr,
  output logic      [SEL_W-1:0] o_wb_sel,
  output logic      [DAT_W-1:0] o_wb_dat
);
  int unsigned hangs;

  initial begin
    hangs = 0;
    o_wb_cyc = 1'b0;
    o_wb_stb = 1'b0;
    o_wb_we = 1'b0;
    o_wb_adr = '0;
    o_wb_sel = '0;
    o_wb_dat = '0;
  end

  // one classic cycle; released write data is inverted so a stale word never looks valid
  task automatic xfer(input logic we, input logic [ADR_W-1:0] adr,
                      input logic [DAT_W-1:0] wdat, output logic [DAT_W-1:0] rdat);
    int n;
    @(posedge i_mclk);
    o_wb_cyc <= 1'b1;
    o_wb_stb <= 1'b1;
    o_wb_we <= we;
    o_wb_adr <= adr;
    o_wb_sel <= 4'hf;
    o_wb_dat <= wdat;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (i_wb_ack !== 1'b1 && n < 16);
    if (i_wb_ack !== 1'b1) hangs++;
    rdat = i_wb_dat;
    o_wb_cyc <= 1'b0;
    o_wb_stb <= 1'b0;
    o_wb_we <= 1'b0;
    o_wb_dat <= ~wdat;
  endtask : xfer
endmodule : macfs_host_model

// ---- tb/tb.sv ----
// self-checking bench for the format and status block
`timescale 1ns/100ps
module tb
  import macfs_pkg::*;
;
  logic              i_mclk;
  logic              i_arst_n;
  logic              wb_cyc, wb_stb, wb_we, wb_ack;
  logic [ADR_W-1:0]  wb_adr;
  logic [SEL_W-1:0]  wb_sel;
  logic [DAT_W-1:0]  wb_wdat, wb_rdat, a, b, q, v, ex;
  macfs_stat_s       st;
  macfs_op_e         op;
  logic [32:0]       sum;
  logic signed [39:0] p, acc_m;
  logic [1:0]        av_st;
  logic              u, f, s, ov, h;
  int                errors, compares, k;
  logic [15:0]       fac [12] = '{16'h0080, 16'h0100, 16'h0180, 16'h0100, 16'h0003, 16'h2aab,
                                  16'h0005, 16'h4ccd, 16'h0007, 16'h1249, 16'h00c5, 16'h01f3};
  logic [63:0]       cor [3] = '{{32'h7fff_ffff, 32'h1}, {32'h8000_0000, 32'h8000_0000},
                                 {32'hffff_ffff, 32'h1}};

  macfs_core u_macfs_core (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_wb_cyc(wb_cyc),
    .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
    .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_status(st));
  macfs_host_model u_macfs_host_model (.i_mclk(i_mclk), .i_wb_ack(wb_ack), .i_wb_dat(wb_rdat),
    .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb), .o_wb_we(wb_we), .o_wb_adr(wb_adr),
    .o_wb_sel(wb_sel), .o_wb_dat(wb_wdat));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    u_macfs_host_model.xfer(we, adr, d, q);
    // results and status commit on the ack edge; look only once they have settled
    @(negedge i_mclk);
    if (u_macfs_host_model.hangs != 0) begin
      $display("BAD %0t no ack", $time);
      errors++;
      wrap_up();
    end
  endtask : bus

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr);
    bus(1'b0, adr, 32'h0);
  endtask : rd

  task automatic run(input macfs_op_e o, input logic un, input logic sb, input logic rn);
    wr(OFF_CMD, {24'h0, 1'b0, rn, sb, un, o});
  endtask : run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk_flag

  function automatic logic [31:0] ld_exp(macfs_op_e o, logic [31:0] d, logic [1:0] ln);
    logic [15:0] h;
    logic [7:0]  y;
    h = ln[1] ? d[31:16] : d[15:0];
    y = d[8*ln +: 8];
    case (o)
      OP_LDU16:  return {16'h0, h};
      OP_LDU8:   return {24'h0, y};
      OP_LDS8:   return {{24{y[7]}}, y};
      OP_PACKED: return d;
      OP_LDFRAC: return {{16{d[15]}}, d[15:0]};
      default:   return {{16{h[15]}}, h};
    endcase
  endfunction : ld_exp

  function automatic logic [15:0] rnd_exp(logic [31:0] d, logic biased);
    logic [31:0] t;
    t = d + 32'h0000_8000;
    if (!biased && d[15:0] == 16'h8000) t[16] = 1'b0;
    return t[31:16];
  endfunction : rnd_exp

  function automatic logic [31:0] sh_exp(macfs_op_e o, logic [31:0] d, logic [4:0] n);
    logic [31:0] e;
    e = 32'h0;
    case (o)
      OP_LSL:  return d << n;
      OP_LSR:  return d >> n;
      OP_ASR:  return $signed(d) >>> n;
      default: begin
        for (int i = 30; i >= 0 && d[i] == d[31]; i--) e++;
        return e;
      end
    endcase
  endfunction : sh_exp

  // true when the accumulator value does not fit a signed 32-bit word
  function automatic logic big(logic signed [39:0] x);
    return x > 40'sh007fffffff || x < -40'sh0080000000;
  endfunction : big

  initial begin
    #2500000;
    errors++;
    $display("BAD %0t timeout", $time);
    wrap_up();
  end

  initial begin
    i_arst_n = 1'b0;
    errors = 0;
    compares = 0;
    av_st = 2'h0;
    acc_m = '0;
    void'($urandom(51653));
    repeat (5) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    // every load kind, random lanes, sign bits set in the corner cases
    for (int i = 0; i < 36; i++) begin
      op = macfs_op_e'(i % 6);
      a = (i < 6) ? 32'h8080_8080 : $urandom;
      b = $urandom;
      wr(OFF_OPA, a);
      wr(OFF_OPB, b);
      run(op, 1'b0, 1'b0, 1'b0);
      rd(OFF_RES);
      chk_word(q, ld_exp(op, a, b[1:0]), "load");
    end
    $display("test loads done");
    // multiply-accumulate on the second accumulator, both modes, add and subtract
    for (int i = 0; i < 20; i++) begin
      f = i[1];
      s = 1'($urandom);
      a = (i < 2) ? 32'h8000 : $urandom;
      b = (i < 2) ? 32'h8000 : $urandom;
      wr(OFF_CTRL, {30'h0, f, 1'b0});
      wr(OFF_OPA, a);
      wr(OFF_OPB, b);
      run(OP_MAC, 1'b1, s, 1'b0);
      p = $signed(a[15:0]) * $signed(b[15:0]);
      if (f) p = p <<< 1;
      acc_m = s ? acc_m - p : acc_m + p;
      rd(OFF_A1W);
      chk_word(q, acc_m[31:0], "acc low");
      rd(OFF_A1X);
      chk_word(q, {{24{acc_m[39]}}, acc_m[39:32]}, "acc ext");
    end
    $display("test mac done");
    // midpoint and near-midpoint values rounded both ways, accumulator left intact
    for (int i = 0; i < 6; i++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_OPA, {16'h0, fac[2*i]});
      wr(OFF_OPB, {16'h0, fac[2*i+1]});
      run(OP_MAC, 1'b0, 1'b0, 1'b0);
      v = 32'(fac[2*i]) * 32'(fac[2*i+1]);
      for (int r = 0; r < 2; r++) begin
        wr(OFF_CTRL, 32'(r));
        run(OP_XFER, 1'b0, 1'b0, 1'b1);
        rd(OFF_RND);
        chk_word({16'h0, q[15:0]}, {16'h0, rnd_exp(v, r[0])}, "round");
        rd(OFF_A0W);
        chk_word(q, v, "acc kept");
      end
      chk_flag(st.acc_transfer_overflow, big(acc_m), "xfer ov");
      run(OP_MAC, 1'b0, 1'b1, 1'b0);
    end
    $display("test rounding done");
    // push the accumulator past the signed 32-bit range, transfer, then bring it back
    wr(OFF_CTRL, 32'h0);
    wr(OFF_OPA, 32'h7fff);
    wr(OFF_OPB, 32'h7fff);
    repeat (3) run(OP_MAC, 1'b0, 1'b0, 1'b0);
    run(OP_XFER, 1'b0, 1'b0, 1'b0);
    rd(OFF_RES);
    chk_word(q, 32'hbffd_0003, "xfer res");
    chk_flag(st.acc_transfer_overflow, 1'b1, "xfer ov");
    chk_flag(st.acc_transfer_overflow_sticky, 1'b1, "xfer st");
    repeat (3) run(OP_MAC, 1'b0, 1'b1, 1'b0);
    run(OP_XFER, 1'b0, 1'b0, 1'b0);
    chk_flag(st.acc_transfer_overflow, big(acc_m), "xfer ov");
    chk_flag(st.acc_transfer_overflow_sticky, 1'b1, "xfer st");
    $display("test transfer done");
    // add and subtract, 32 and 16 bit, both units, overflow and carry corners first
    for (int i = 0; i < 24; i++) begin
      u = i[0];
      h = i[2];
      s = i[3];
      {a, b} = (i < 3) ? cor[i] : {32'($urandom), 32'($urandom)};
      ex = s ? ~b : b;
      k = h ? 15 : 31;
      wr(OFF_OPA, a);
      wr(OFF_OPB, b);
      wr(OFF_CMD, {24'h0, h, 1'b0, s, u, OP_ADD});
      sum = h ? 33'({1'b0, a[15:0]} + {1'b0, ex[15:0]} + s) : {1'b0, a} + {1'b0, ex} + s;
      ov = (a[k] == ex[k]) && (sum[k] != a[k]);
      av_st[u] = av_st[u] | ov;
      rd(OFF_RES);
      chk_word(q, h ? {16'h0, sum[15:0]} : sum[31:0], "add");
      chk_flag(u ? st.alu1_carry : st.alu0_carry, sum[k+1], "carry");
      chk_flag(u ? st.alu1_overflow : st.alu0_overflow, ov, "ovf");
      chk_flag(st.alu_negative_flag, sum[k], "neg");
      chk_flag(u ? st.alu1_overflow_sticky : st.alu0_overflow_sticky, av_st[u], "st");
    end
    wr(OFF_STAT, 32'h0);
    chk_word(32'(st), 32'h0, "stat clear");
    $display("test add done");
    for (int i = 0; i < 30; i++) begin
      op = macfs_op_e'(OP_LSL + i % 4);
      a = (i < 3) ? 32'h8000_0001 : (i == 3) ? 32'hfff0_0000 : $urandom;
      b = (i < 4) ? 32'h1f : $urandom;
      wr(OFF_OPA, a);
      wr(OFF_OPB, b);
      run(op, 1'b0, 1'b0, 1'b0);
      rd(OFF_RES);
      chk_word(q, sh_exp(op, a, b[4:0]), "shift");
    end
    $display("test shift done");
    // unmapped reads give zero, the result word ignores writes
    rd(8'h40);
    chk_word(q, 32'h0, "unmapped");
    rd(OFF_RES);
    v = q;
    wr(OFF_RES, ~v);
    rd(OFF_RES);
    chk_word(q, v, "ro");
    $display("test bus done");
    wrap_up();
  end
endmodule : tb
